// ### windowed_watchdog_timer_tb_top.sv
// Self-checking testbench of the windowed watchdog timer
`timescale 1ns/1ps
module windowed_watchdog_timer_tb_top;
	import wwdt_pkg::*;
	localparam int DIV = 2;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	wire logic hready;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [7:0] config_bits = 8'hc0;
	logic clr_i = 1'b0;
	logic ps_i = 1'b0;
	logic ps_idle = 1'b0;
	logic wake_ev = 1'b0;
	logic csw = 1'b0;
	logic wdt_reset_req;
	logic wake_req;
	logic low_power_rc_osc_enable;
	logic sleep_active;
	int mismatches = 0;
	int compares = 0;
	int n;
	logic w;
	assign hready = hreadyout;

	wwdt_top #(.LOW_POWER_RC_OSC_DIV(DIV)) i_wwdt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .config_bits(config_bits),
		.clear_counter_instr(clr_i), .power_save_instr(ps_i), .power_save_idle(ps_idle),
		.wake_event(wake_ev), .clock_switch_done(csw), .wdt_reset_req(wdt_reset_req),
		.wake_req(wake_req), .low_power_rc_osc_enable(low_power_rc_osc_enable), .sleep_active(sleep_active));

	initial begin
		forever #10 hclk = ~hclk;
	end

	// ********************************************************
	// Shared tasks
	// ********************************************************
	task summarize;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task near(input int got, input int exp);
		compares++;
		if (got < exp - DIV - 4 || got > exp + DIV + 4) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wait_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			i++;
			if (i > 100) begin
				mismatches++;
				summarize;
			end
			@(posedge hclk);
		end
	endtask

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask

	task rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task do_reset(input logic [7:0] cfg);
		@(posedge hclk);
		hresetn <= 1'b0;
		config_bits <= cfg;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (5) @(posedge hclk);
	endtask

	// One-cycle core event: 0 clear, 1 power save, 2 wake, 3 clock switch
	task ev(input int k);
		@(posedge hclk);
		case (k)
			0: clr_i <= 1'b1;
			1: ps_i <= 1'b1;
			2: wake_ev <= 1'b1;
			default: csw <= 1'b1;
		endcase
		@(posedge hclk);
		clr_i <= 1'b0;
		ps_i <= 1'b0;
		wake_ev <= 1'b0;
		csw <= 1'b0;
	endtask

	task measure;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
			if (n > 3000) begin
				$display("wrong value at %0t: got %h expected %h", $time, n, 0);
				mismatches++;
				summarize;
			end
		end while (!(wdt_reset_req === 1'b1 || wake_req === 1'b1));
		w = wake_req;
	endtask

	// ********************************************************
	// Scenarios
	// ********************************************************
	task t_periods;
		logic [7:0] cfgs [3] = '{8'hc0, 8'hd0, 8'hc3};
		int ticks [3] = '{32, 128, 256};
		for (int i = 0; i < 3; i++) begin
			do_reset(cfgs[i]);
			ev(0);
			measure;
			near(n, ticks[i] * DIV);
			chk(w, 1'b0);
			rd(WWDT_RCTL_OFS, 32'h10);
			repeat (20) @(posedge hclk);
			rd(WWDT_RCTL_OFS, 32'h10);
			wr(WWDT_RCTL_OFS, 32'h0);
			rd(WWDT_RCTL_OFS, 32'h0);
		end
	endtask

	task t_clear_events;
		int k [2] = '{0, 3};
		do_reset(8'hc0);
		for (int i = 0; i < 2; i++) begin
			ev(0);
			repeat (40) @(posedge hclk);
			ev(k[i]);
			measure;
			near(n, 32 * DIV);
		end
	endtask

	task t_sleep;
		for (int i = 0; i < 2; i++) begin
			do_reset(8'hc0);
			ps_idle <= i[0];
			ev(0);
			repeat (30) @(posedge hclk);
			ev(1);
			@(negedge hclk);
			chk(sleep_active, 1'b1);
			measure;
			near(n, 32 * DIV);
			chk(w, 1'b1);
			@(negedge hclk);
			chk(sleep_active, 1'b0);
			rd(WWDT_RCTL_OFS, i ? 32'h14 : 32'h18);
			wr(WWDT_RCTL_OFS, 32'h0);
			rd(WWDT_RCTL_OFS, 32'h0);
		end
	endtask

	task t_wake;
		do_reset(8'hc0);
		ps_idle <= 1'b0;
		ev(1);
		repeat (20) @(posedge hclk);
		ev(2);
		@(negedge hclk);
		chk(sleep_active, 1'b0);
		measure;
		near(n, 32 * DIV);
		chk(w, 1'b0);
	endtask

	task t_window;
		do_reset(8'h80);
		rd(WWDT_CFG_OFS, 32'h80);
		ev(0);
		repeat (10) @(posedge hclk);
		ev(0);
		measure;
		near(n, 2);
		chk(w, 1'b0);
		rd(WWDT_RCTL_OFS, 32'h10);
		repeat (52) @(posedge hclk);
		ev(0);
		measure;
		near(n, 32 * DIV);
	endtask

	task t_enable;
		do_reset(8'h40);
		@(negedge hclk);
		chk(low_power_rc_osc_enable, 1'b0);
		rd(WWDT_RCTL_OFS, 32'h0);
		rd(WWDT_CFG_OFS, 32'h40);
		wr(WWDT_CFG_OFS, 32'h0);
		rd(WWDT_CFG_OFS, 32'h40);
		rd(32'h0000_0010, 32'h0);
		chk({hreadyout, hresp}, 32'h2);
		wr(WWDT_RCTL_OFS, 32'h20);
		repeat (2) @(negedge hclk);
		chk(low_power_rc_osc_enable, 1'b1);
		wr(WWDT_RCTL_OFS, 32'h0);
		repeat (2) @(negedge hclk);
		chk(low_power_rc_osc_enable, 1'b0);
		wr(WWDT_RCTL_OFS, 32'h20);
		do_reset(8'h40);
		rd(WWDT_RCTL_OFS, 32'h0);
		do_reset(8'hc0);
		wr(WWDT_RCTL_OFS, 32'h0);
		repeat (2) @(negedge hclk);
		chk(low_power_rc_osc_enable, 1'b1);
	endtask

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		t_enable;
		t_periods;
		t_clear_events;
		t_sleep;
		t_wake;
		t_window;
		summarize;
	end

endmodule // windowed_watchdog_timer_tb_top

// ### wwdt_link_if.sv
// Interface joining the watchdog top, its oscillator tick and its counter
`timescale 1ns/1ps
interface wwdt_link_if;
	import wwdt_pkg::*;
	logic osc_en;
	logic tick;
	logic clear;
	logic pre_sel;
	logic [3:0] post_sel;
	logic [WWDT_CNT_W-1:0] count;
	logic timeout;
	logic window_open;
	modport ctrl(output osc_en, output clear, output pre_sel, output post_sel,
		input tick, input count, input timeout, input window_open);
	modport osc(input osc_en, output tick);
	modport scaler(input tick, input clear, input pre_sel, input post_sel,
		output count, output timeout, output window_open);
endinterface

// ### wwdt_low_power_rc_osc.sv
// Tick source standing for the low-power RC oscillator
`timescale 1ns/1ps
module wwdt_low_power_rc_osc #(
	parameter int DIV = wwdt_pkg::WWDT_LOW_POWER_RC_OSC_DIV_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	wwdt_link_if.osc lnk
);
	import wwdt_pkg::*;

	logic [15:0] div_reg;
	logic tick_reg;
	logic [15:0] gap_reg;

	initial begin
		if (DIV < 2 || DIV > 65535) begin
			$error("wwdt_low_power_rc_osc: DIV out of range");
		end
	end

	// ********************************************************
	// Divider runs only while the oscillator is enabled
	// ********************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (!lnk.osc_en) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (div_reg == 16'(DIV - 1)) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			div_reg <= div_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	assign lnk.tick = tick_reg;

	// Helper: cycles since the last tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_reg <= 16'h0000;
		end else if (!lnk.osc_en) begin
			gap_reg <= 16'h0000;
		end else if (tick_reg) begin
			gap_reg <= 16'h0001;
		end else begin
			gap_reg <= gap_reg + 16'h0001;
		end
	end

	a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
		(tick_reg && $past(tick_reg, 1) == 1'b0 && lnk.osc_en && gap_reg > 16'h0001) |-> gap_reg == 16'(DIV))
		else $error("oscillator tick spacing wrong");

endmodule // wwdt_low_power_rc_osc

// ### wwdt_pkg.sv
// Package of constants, types and helpers for the windowed watchdog timer
package wwdt_pkg;

	// ********************************************************
	// Register map and field layout
	// ********************************************************
	localparam logic [31:0] WWDT_CFG_OFS = 32'h0000_0000;
	localparam logic [31:0] WWDT_RCTL_OFS = 32'h0000_0004;
	localparam logic [31:0] WWDT_STAT_OFS = 32'h0000_0008;
	localparam int WWDT_CFG_POST_LSB = 0;
	localparam int WWDT_CFG_PRE_BIT = 4;
	localparam int WWDT_CFG_WINOFF_BIT = 6;
	localparam int WWDT_CFG_FIXEN_BIT = 7;
	localparam int WWDT_RCTL_SOFTEN_BIT = 5;
	localparam int WWDT_RCTL_TO_BIT = 4;
	localparam int WWDT_RCTL_SLEEP_BIT = 3;
	localparam int WWDT_RCTL_IDLE_BIT = 2;
	localparam int WWDT_STAT_WIN_BIT = 24;
	localparam int WWDT_STAT_STATE_LSB = 25;
	localparam int WWDT_STAT_OSC_BIT = 27;
	localparam logic [7:0] WWDT_CFG_RESET = 8'hff;
	localparam logic [1:0] WWDT_CFG_LOAD_CYC = 2'h2;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int WWDT_HCLK_PERIOD_NS = 20;
	localparam int WWDT_LOW_POWER_RC_OSC_FREQ_HZ = 32000;
	localparam int WWDT_LOW_POWER_RC_OSC_PERIOD_NS = 1000000000 / WWDT_LOW_POWER_RC_OSC_FREQ_HZ;
	localparam int WWDT_LOW_POWER_RC_OSC_DIV_CYC = WWDT_LOW_POWER_RC_OSC_PERIOD_NS / WWDT_HCLK_PERIOD_NS;
	localparam int WWDT_BASE_TO_SHORT_US = 1000;
	localparam int WWDT_BASE_TO_LONG_US = 4000;
	localparam int WWDT_PRE_SHORT_TICKS = WWDT_BASE_TO_SHORT_US * 1000 / WWDT_LOW_POWER_RC_OSC_PERIOD_NS;
	localparam int WWDT_PRE_LONG_TICKS = WWDT_BASE_TO_LONG_US * 1000 / WWDT_LOW_POWER_RC_OSC_PERIOD_NS;
	localparam logic [4:0] WWDT_PRE_LOG_SHORT = 5'h05;
	localparam logic [4:0] WWDT_PRE_LOG_LONG = 5'h07;
	localparam int WWDT_CNT_W = 23;

	// ********************************************************
	// Types and helpers
	// ********************************************************
	typedef enum logic [1:0] {
		WWDT_RUN = 2'b00,
		WWDT_SLEEP = 2'b01,
		WWDT_IDLE = 2'b10
	} wwdt_state_t;

	// Total ticks per time-out: prescale times two to the postscale code
	function automatic logic [WWDT_CNT_W-1:0] wwdt_period(input logic pre_sel, input logic [3:0] post_sel);
		logic [4:0] sh;
		sh = (pre_sel ? WWDT_PRE_LOG_LONG : WWDT_PRE_LOG_SHORT) + {1'b0, post_sel};
		return {{(WWDT_CNT_W-1){1'b0}}, 1'b1} << sh;
	endfunction

endpackage

// ### wwdt_scaler.sv
// Combined prescaler and postscaler counter of the watchdog
`timescale 1ns/1ps
module wwdt_scaler (
	input wire logic hclk,
	input wire logic hresetn,
	wwdt_link_if.scaler lnk
);
	import wwdt_pkg::*;

	logic [WWDT_CNT_W-1:0] count_reg;
	logic timeout_reg;
	logic [WWDT_CNT_W-1:0] period;

	assign period = wwdt_period(lnk.pre_sel, lnk.post_sel);

	// ********************************************************
	// Counter, wrap and time-out pulse
	// ********************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= '0;
			timeout_reg <= 1'b0;
		end else if (lnk.clear) begin
			count_reg <= '0;
			timeout_reg <= 1'b0;
		end else if (lnk.tick && count_reg >= period - 1'b1) begin
			count_reg <= '0;
			timeout_reg <= 1'b1;
		end else if (lnk.tick) begin
			count_reg <= count_reg + 1'b1;
			timeout_reg <= 1'b0;
		end else begin
			timeout_reg <= 1'b0;
		end
	end

	assign lnk.count = count_reg;
	assign lnk.timeout = timeout_reg;
	assign lnk.window_open = count_reg >= (period - (period >> 2));

	// a tick at the full count gives a time-out and wraps the count to zero
	a_timeout_count: assert property (@(posedge hclk) disable iff (!hresetn)
		(lnk.tick && !lnk.clear && count_reg == period - 1'b1) |=> (timeout_reg && count_reg == '0))
		else $error("time-out not at full count");

	// short ratio gives 32 ticks per step
	a_prescale_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
		(!lnk.pre_sel && lnk.post_sel == 4'h0) |-> period == WWDT_CNT_W'(32))
		else $error("prescale ratio wrong");

endmodule // wwdt_scaler

// ### wwdt_top.sv
// Windowed watchdog timer top with an AHB-Lite register slave
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module wwdt_top #(
	parameter int LOW_POWER_RC_OSC_DIV = wwdt_pkg::WWDT_LOW_POWER_RC_OSC_DIV_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [7:0] config_bits,
	input wire logic clear_counter_instr,
	input wire logic power_save_instr,
	input wire logic power_save_idle,
	input wire logic wake_event,
	input wire logic clock_switch_done,
	output logic wdt_reset_req,
	output logic wake_req,
	output logic low_power_rc_osc_enable,
	output logic sleep_active
);
	import wwdt_pkg::*;

	wwdt_link_if lnk();

	logic [7:0] cfg_meta_reg;
	logic [7:0] cfg_sync_reg;
	logic [1:0] cfg_cnt_reg;
	logic [7:0] watchdog_config_reg;
	logic soft_enable_reg;
	logic timeout_flag_reg;
	logic sleep_flag_reg;
	logic idle_flag_reg;
	wwdt_state_t state_reg;
	wwdt_state_t state_next;
	logic wdt_reset_reg;
	logic wake_reg;
	logic sleep_active_reg;
	logic osc_en_reg;
	logic wr_pend_reg;
	logic [31:0] wr_addr_reg;
	logic [31:0] hrdata_reg;
	logic wdt_on;
	logic fixed_enable_cfg;
	logic window_off_cfg;
	logic addr_phase;
	logic early_clear;
	logic sleep_timeout;
	logic rctl_write;
	logic [31:0] rd_word;

	initial begin
		if (LOW_POWER_RC_OSC_DIV < 2 || LOW_POWER_RC_OSC_DIV > 65535) begin
			$error("wwdt_top: LOW_POWER_RC_OSC_DIV out of range");
		end
		if (WWDT_PRE_SHORT_TICKS != 32 || WWDT_PRE_LONG_TICKS != 128) begin
			$error("wwdt_top: base time-out does not match prescale ratios");
		end
	end

	// ********************************************************
	// Submodules
	// ********************************************************
	wwdt_low_power_rc_osc #(.DIV(LOW_POWER_RC_OSC_DIV)) u_low_power_rc_osc (
		.hclk(hclk),
		.hresetn(hresetn),
		.lnk(lnk.osc)
	);

	wwdt_scaler u_scaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.lnk(lnk.scaler)
	);

	// ********************************************************
	// Configuration capture after reset release
	// ********************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_meta_reg <= WWDT_CFG_RESET;
			cfg_sync_reg <= WWDT_CFG_RESET;
		end else begin
			cfg_meta_reg <= config_bits;
			cfg_sync_reg <= cfg_meta_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_cnt_reg <= 2'h0;
			watchdog_config_reg <= WWDT_CFG_RESET;
		end else if (cfg_cnt_reg != 2'h3) begin
			cfg_cnt_reg <= cfg_cnt_reg + 2'h1;
			if (cfg_cnt_reg == WWDT_CFG_LOAD_CYC) begin
				watchdog_config_reg <= cfg_sync_reg;
			end
		end
	end

	assign fixed_enable_cfg = watchdog_config_reg[WWDT_CFG_FIXEN_BIT];
	assign window_off_cfg = watchdog_config_reg[WWDT_CFG_WINOFF_BIT];
	assign wdt_on = fixed_enable_cfg | soft_enable_reg;

	assign lnk.pre_sel = watchdog_config_reg[WWDT_CFG_PRE_BIT];
	assign lnk.post_sel = watchdog_config_reg[WWDT_CFG_POST_LSB +: 4];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_en_reg <= 1'b0;
		end else begin
			osc_en_reg <= wdt_on;
		end
	end
	assign lnk.osc_en = osc_en_reg;

	// ********************************************************
	// Power-save state and counter clears
	// ********************************************************
	assign sleep_timeout = lnk.timeout && state_reg != WWDT_RUN;
	assign early_clear = state_reg == WWDT_RUN && clear_counter_instr && wdt_on && !window_off_cfg
		&& !lnk.window_open;

	assign lnk.clear = !wdt_on || clock_switch_done
		|| (state_reg == WWDT_RUN && (power_save_instr || clear_counter_instr))
		|| (state_reg != WWDT_RUN && (wake_event || lnk.timeout));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			WWDT_RUN: begin
				if (power_save_instr) begin
					state_next = power_save_idle ? WWDT_IDLE : WWDT_SLEEP;
				end
			end
			WWDT_SLEEP, WWDT_IDLE: begin
				if (wake_event || lnk.timeout) begin
					state_next = WWDT_RUN;
				end
			end
			default: begin
				state_next = WWDT_RUN;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= WWDT_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Registered copy of the power-save state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_active_reg <= 1'b0;
		end else begin
			sleep_active_reg <= state_next != WWDT_RUN;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_reset_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			wdt_reset_reg <= (lnk.timeout && state_reg == WWDT_RUN) || early_clear;
			wake_reg <= sleep_timeout;
		end
	end

	// ********************************************************
	// AHB-Lite slave
	// ********************************************************
	assign addr_phase = hsel && htrans[1] && hready;
	assign rctl_write = wr_pend_reg && wr_addr_reg == WWDT_RCTL_OFS;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (haddr == WWDT_CFG_OFS) begin
			rd_word[7:0] = watchdog_config_reg;
		end else if (haddr == WWDT_RCTL_OFS) begin
			rd_word[WWDT_RCTL_SOFTEN_BIT] = soft_enable_reg;
			rd_word[WWDT_RCTL_TO_BIT] = timeout_flag_reg;
			rd_word[WWDT_RCTL_SLEEP_BIT] = sleep_flag_reg;
			rd_word[WWDT_RCTL_IDLE_BIT] = idle_flag_reg;
		end else if (haddr == WWDT_STAT_OFS) begin
			rd_word[WWDT_CNT_W-1:0] = lnk.count;
			rd_word[WWDT_STAT_WIN_BIT] = lnk.window_open;
			rd_word[WWDT_STAT_STATE_LSB +: 2] = state_reg;
			rd_word[WWDT_STAT_OSC_BIT] = osc_en_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 32'h0000_0000;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_addr_reg <= haddr;
			end
			if (addr_phase && !hwrite) begin
				hrdata_reg <= rd_word;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			soft_enable_reg <= 1'b0;
		end else if (rctl_write) begin
			soft_enable_reg <= hwdata[WWDT_RCTL_SOFTEN_BIT];
		end
	end

	// time-out flag, set wins over a software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timeout_flag_reg <= 1'b0;
		end else if (lnk.timeout || early_clear) begin
			timeout_flag_reg <= 1'b1;
		end else if (rctl_write && !hwdata[WWDT_RCTL_TO_BIT]) begin
			timeout_flag_reg <= 1'b0;
		end
	end

	// power-save flags held until software clears them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_flag_reg <= 1'b0;
			idle_flag_reg <= 1'b0;
		end else begin
			if (state_reg == WWDT_RUN && power_save_instr && !power_save_idle) begin
				sleep_flag_reg <= 1'b1;
			end else if (rctl_write && !hwdata[WWDT_RCTL_SLEEP_BIT]) begin
				sleep_flag_reg <= 1'b0;
			end
			if (state_reg == WWDT_RUN && power_save_instr && power_save_idle) begin
				idle_flag_reg <= 1'b1;
			end else if (rctl_write && !hwdata[WWDT_RCTL_IDLE_BIT]) begin
				idle_flag_reg <= 1'b0;
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign wdt_reset_req = wdt_reset_reg;
	assign wake_req = wake_reg;
	assign low_power_rc_osc_enable = osc_en_reg;
	assign sleep_active = sleep_active_reg;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_sleep_timeout;
		state_reg != WWDT_RUN ##0 lnk.timeout;
	endsequence

	sequence s_woken;
		wake_reg && state_reg == WWDT_RUN && lnk.count == '0;
	endsequence

	a_osc_follows_en: assert property (wdt_on |=> low_power_rc_osc_enable)
		else $error("oscillator not enabled with watchdog");
	a_fixed_enable_on: assert property ((fixed_enable_cfg && rctl_write && !hwdata[WWDT_RCTL_SOFTEN_BIT]) |=>
		##1 low_power_rc_osc_enable)
		else $error("fixed enable does not hold watchdog on");
	a_switch_clears: assert property (clock_switch_done |=> lnk.count == '0)
		else $error("clock switch did not clear counter");
	a_psave_clears: assert property ((state_reg == WWDT_RUN && power_save_instr) |=>
		(lnk.count == '0 && sleep_active))
		else $error("power save entry did not clear counter");
	a_clear_instr: assert property ((state_reg == WWDT_RUN && clear_counter_instr) |=> lnk.count == '0)
		else $error("clear instruction did not clear counter");
	a_sleep_wake: assert property (s_sleep_timeout |=> s_woken)
		else $error("time-out in power save did not wake");
	a_sleep_flag_hold: assert property ((sleep_flag_reg && !rctl_write) |=> sleep_flag_reg)
		else $error("sleep flag dropped without software");
	a_soft_en_reset: assert property ($rose(hresetn) |-> !soft_enable_reg)
		else $error("soft enable not cleared by reset");
	a_timeout_flag: assert property (lnk.timeout |=> timeout_flag_reg ##1 (timeout_flag_reg || $past(rctl_write)))
		else $error("time-out flag not kept");
	a_early_clear: assert property (early_clear |=> wdt_reset_req ##1 !wdt_reset_req || $past(early_clear))
		else $error("early clear did not reset");
	a_run_timeout: assert property ((lnk.timeout && state_reg == WWDT_RUN) |=>
		(wdt_reset_req && timeout_flag_reg && !wake_req))
		else $error("running time-out did not request reset");
	a_window_mode: assert property ((window_off_cfg && clear_counter_instr) |=> !wdt_reset_req
		|| $past(lnk.timeout))
		else $error("non-window mode reset on clear");
	a_sleep_flag_set: assert property ((state_reg == WWDT_RUN && power_save_instr && !power_save_idle) |=>
		sleep_flag_reg)
		else $error("sleep flag not set on entry");
	a_idle_flag_hold: assert property ((idle_flag_reg && !rctl_write) |=> idle_flag_reg)
		else $error("idle flag dropped without software");
	a_disabled_idle: assert property (!wdt_on |=> (lnk.count == '0 && !lnk.timeout))
		else $error("disabled watchdog kept counting");
	a_window_clear_ok: assert property ((state_reg == WWDT_RUN && clear_counter_instr && lnk.window_open
		&& !lnk.timeout) |=> !wdt_reset_req)
		else $error("clear inside the window caused a reset");
	a_wake_exit_clears: assert property ((state_reg != WWDT_RUN && wake_event) |=>
		(lnk.count == '0 && !sleep_active))
		else $error("leaving power save did not clear counter");

endmodule // wwdt_top
